/* File: shared/pmcc_defs.vh */
// Purpose: constants for the power mode clock control block
// Assumes: sfr addresses are 8 bits wide
// Notes:   included by bare name from the design files
`ifndef PMCC_DEFS_VH
`define PMCC_DEFS_VH

`define PMCC_ADDR_POWER_CFG    8'h87
`define PMCC_ADDR_ACT_STATUS   8'hE9
`define PMCC_POWER_CFG_RESET   8'h00
`define PMCC_POWER_CFG_WMASK   8'hFF
`define PMCC_STATUS_RSVD_MASK  8'h6F

`define PMCC_BIT_RSMODE        0
`define PMCC_BIT_STOP          1
`define PMCC_BIT_SWB           2
`define PMCC_BIT_REG_STBY      3
`define PMCC_BIT_PWE           4
`define PMCC_BIT_U1_DBL        6
`define PMCC_BIT_U0_DBL        7

`define PMCC_DIV_RATIO         7'h64
`define PMCC_DIV_LAST          7'h63

`define PMCC_MODE_FULL         2'h0
`define PMCC_MODE_REDUCED      2'h1
`define PMCC_MODE_STOP         2'h2

`define PMCC_RATE_25MHZ        2'h0
`define PMCC_RATE_50MHZ        2'h1
`define PMCC_RATE_100MHZ       2'h2

`endif

/* File: logic/pmcc_edge_detect.v */
// Purpose: falling edge detection on two receive pins
// Assumes: pins already synchronous to clk_i
// Notes:   one-cycle pulse per falling edge
`timescale 1ns/10ps
`default_nettype none
module pmcc_edge_detect (
  input  wire       clk_i,   // system clock
  input  wire       srst_i,  // sync reset, high
  input  wire [1:0] pin_i,   // receive pins
  output wire [1:0] fall_o   // falling edge pulses
);
  reg [1:0] last;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_pin
      // idle line is high, so reset to high avoids a false edge
      always @(posedge clk_i) begin
        if (srst_i)
          last[g] <= 1'b1;
        else
          last[g] <= pin_i[g];
      end
      assign fall_o[g] = last[g] & ~pin_i[g];
    end
  endgenerate
endmodule
`default_nettype wire

/* File: logic/pmcc_divider.v */
// Purpose: divide-by-100 tick for the reduced speed clock
// Assumes: enable_i is a level from the mode logic
// Notes:   tick is high every cycle when disabled (full rate)
`include "pmcc_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module pmcc_divider (
  input  wire clk_i,     // system clock
  input  wire srst_i,    // sync reset, high
  input  wire enable_i,  // divide active
  output reg  tick_o     // enable for divided logic
);
  reg [6:0] count;
  always @(posedge clk_i) begin
    if (srst_i || !enable_i) begin
      count  <= 7'h00;
      tick_o <= 1'b1;
    end else begin
      if (count == `PMCC_DIV_LAST)
        count <= 7'h00;
      else
        count <= count + 7'h01;
      tick_o <= (count == `PMCC_DIV_LAST);
    end
  end
endmodule
`default_nettype wire

/* File: logic/pmcc_top.v */
// Purpose: power mode controller: full speed, reduced speed, stop
// Assumes: sfr bus is synchronous, one-cycle write strobe, registered read
// Notes:   clock generator applies rate, divide and gate outputs
`include "pmcc_defs.vh"
`timescale 1ns/10ps
`default_nettype none

module pmcc_top (
  input  wire       clk_i,                  // system clock
  input  wire       srst_i,                 // sync reset, high
  input  wire [7:0] sfr_addr_i,             // sfr address
  input  wire [7:0] sfr_wdata_i,            // sfr write data
  input  wire       sfr_wr_i,               // sfr write strobe
  input  wire       sfr_rd_i,               // sfr read strobe
  input  wire [1:0] sysclk_rate_select_i,   // full speed rate select
  input  wire       irq_ack_i,              // enabled interrupt acknowledged
  input  wire       uart0_receive_pin_i,    // uart0 receive pin
  input  wire       uart1_receive_pin_i,    // uart1 receive pin
  input  wire       uart0_rx_enable_i,      // uart0 receiver enabled
  input  wire       uart1_rx_enable_i,      // uart1 receiver enabled
  input  wire       uart0_tx_load_i,        // uart0 transmit buffer loaded
  input  wire       uart1_tx_load_i,        // uart1 transmit buffer loaded
  input  wire       uart0_rx_active_i,      // uart0 receiver busy
  input  wire       uart0_tx_active_i,      // uart0 transmitter busy
  input  wire       uart1_rx_active_i,      // uart1 receiver busy
  input  wire       uart1_tx_active_i,      // uart1 transmitter busy
  input  wire       low_prio_irq_active_i,  // low priority in service
  input  wire       high_prio_irq_active_i, // high priority in service
  input  wire       stop_wake_i,            // clock generator woke from stop
  output reg  [7:0] sfr_rdata_o,            // sfr read data
  output reg  [1:0] sysclk_rate_o,          // rate to clock generator
  output reg        clk_divide_o,           // divide system clock by 100
  output reg        clk_gate_off_o,         // system clock gated off
  output reg  [1:0] power_mode_o,           // current mode code
  output reg        slow_tick_o,            // enable for divided-rate logic
  output reg        regulator_standby_o,    // regulator standby select
  output reg        progmem_write_enable_o, // program write during moves
  output reg        uart0_double_baud_o,    // uart0 double baud
  output reg        uart1_double_baud_o     // uart1 double baud
);
  // mode codes follow the power_mode_o encoding
  localparam [1:0] ST_FULL    = `PMCC_MODE_FULL;
  localparam [1:0] ST_REDUCED = `PMCC_MODE_REDUCED;
  localparam [1:0] ST_STOP    = `PMCC_MODE_STOP;

  reg  [7:0] power_configuration;
  reg  [7:0] next_power_configuration;
  reg  [1:0] next_mode;
  reg  [7:0] next_rdata;
  wire [1:0] rx_fall;
  wire [1:0] rx_enable;
  wire [1:0] tx_load;
  wire [1:0] rx_wake;
  wire [1:0] tx_wake;
  wire       irq_wake;
  wire       any_wake;
  wire       div_tick;
  wire       wr_cfg;
  wire       rd_cfg;
  wire       rd_status;
  wire       swb_enabled;
  wire       switchback;
  wire       cfg_reduced;
  wire       cfg_stop;
  wire       cfg_reg_stby;
  wire       cfg_pwe;
  wire       cfg_u1_dbl;
  wire       cfg_u0_dbl;
  wire [7:0] activity_status;
  genvar     u;

  pmcc_edge_detect u_edge (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .pin_i  ({uart1_receive_pin_i, uart0_receive_pin_i}),
    .fall_o (rx_fall)
  );

  pmcc_divider u_div (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .enable_i (clk_divide_o),
    .tick_o   (div_tick)
  );

  // single cycle strobes, no wait states
  assign wr_cfg    = sfr_wr_i && (sfr_addr_i == `PMCC_ADDR_POWER_CFG);
  assign rd_cfg    = sfr_rd_i && (sfr_addr_i == `PMCC_ADDR_POWER_CFG);
  assign rd_status = sfr_rd_i && (sfr_addr_i == `PMCC_ADDR_ACT_STATUS);

  // switchback sources, one lane per uart
  assign rx_enable = {uart1_rx_enable_i, uart0_rx_enable_i};
  assign tx_load   = {uart1_tx_load_i, uart0_tx_load_i};
  assign irq_wake  = irq_ack_i;

  generate
    for (u = 0; u < 2; u = u + 1) begin : g_lane
      // receive edges count only when that receiver is enabled
      assign rx_wake[u] = rx_fall[u] & rx_enable[u];
      // buffer load wakes before the first bit leaves
      assign tx_wake[u] = tx_load[u];
    end
  endgenerate

  assign any_wake    = irq_wake | (|rx_wake) | (|tx_wake);
  assign swb_enabled = power_configuration[`PMCC_BIT_SWB];
  // with the enable bit low no source may touch the reduced speed bit
  assign switchback  = swb_enabled & any_wake;

  always @* begin
    next_power_configuration = power_configuration;
    if (wr_cfg)
      next_power_configuration = sfr_wdata_i & `PMCC_POWER_CFG_WMASK;
    // hardware clear wins over a same-cycle software set of reduced speed
    if (switchback)
      next_power_configuration[`PMCC_BIT_RSMODE] = 1'b0;
    // the clock generator restarts the clock on wake; drop the stop bit
    if (stop_wake_i)
      next_power_configuration[`PMCC_BIT_STOP] = 1'b0;
  end

  // outputs copy the value being stored, so they move with the register
  assign cfg_reduced  = next_power_configuration[`PMCC_BIT_RSMODE];
  assign cfg_stop     = next_power_configuration[`PMCC_BIT_STOP];
  assign cfg_reg_stby = next_power_configuration[`PMCC_BIT_REG_STBY];
  assign cfg_pwe      = next_power_configuration[`PMCC_BIT_PWE];
  assign cfg_u1_dbl   = next_power_configuration[`PMCC_BIT_U1_DBL];
  assign cfg_u0_dbl   = next_power_configuration[`PMCC_BIT_U0_DBL];

  // stop comes first so a reduced speed bit can not reopen the clock
  always @* begin
    case ({cfg_stop, cfg_reduced})
      2'b00:   next_mode = ST_FULL;
      2'b01:   next_mode = ST_REDUCED;
      2'b10:   next_mode = ST_STOP;
      2'b11:   next_mode = ST_STOP;
      default: next_mode = ST_FULL;
    endcase
  end

  always @(posedge clk_i) begin
    if (srst_i)
      power_configuration <= `PMCC_POWER_CFG_RESET;
    else
      power_configuration <= next_power_configuration;
  end

  // a mode change shows one cycle after its cause
  always @(posedge clk_i) begin
    if (srst_i)
      power_mode_o <= ST_FULL;
    else
      power_mode_o <= next_mode;
  end

  always @(posedge clk_i) begin
    if (srst_i)
      clk_divide_o <= 1'b0;
    else
      clk_divide_o <= (next_mode == ST_REDUCED);
  end

  always @(posedge clk_i) begin
    if (srst_i)
      clk_gate_off_o <= 1'b0;
    else
      clk_gate_off_o <= (next_mode == ST_STOP);
  end

  // reserved status bits read zero
  assign activity_status[0] = uart0_rx_active_i;
  assign activity_status[1] = uart0_tx_active_i;
  assign activity_status[2] = uart1_rx_active_i;
  assign activity_status[3] = uart1_tx_active_i;
  assign activity_status[4] = 1'b0;
  assign activity_status[5] = low_prio_irq_active_i;
  assign activity_status[6] = high_prio_irq_active_i;
  assign activity_status[7] = 1'b0;

  // status writes are dropped: the register is read-only
  always @* begin
    case ({rd_status, rd_cfg})
      2'b01:   next_rdata = power_configuration;
      2'b10:   next_rdata = activity_status;
      default: next_rdata = 8'h00;
    endcase
  end

  // read data stands one cycle, then falls back to zero
  always @(posedge clk_i) begin
    if (srst_i)
      sfr_rdata_o <= 8'h00;
    else
      sfr_rdata_o <= next_rdata;
  end

  // rate select passes through even in reduced speed; divide applies on top
  always @(posedge clk_i) begin
    if (srst_i)
      sysclk_rate_o <= `PMCC_RATE_25MHZ;
    else
      sysclk_rate_o <= sysclk_rate_select_i;
  end

  // high at full speed so divided-rate logic runs every cycle
  always @(posedge clk_i) begin
    if (srst_i)
      slow_tick_o <= 1'b1;
    else
      slow_tick_o <= div_tick;
  end

  always @(posedge clk_i) begin
    if (srst_i)
      regulator_standby_o <= 1'b0;
    else
      regulator_standby_o <= cfg_reg_stby;
  end

  always @(posedge clk_i) begin
    if (srst_i)
      progmem_write_enable_o <= 1'b0;
    else
      progmem_write_enable_o <= cfg_pwe;
  end

  always @(posedge clk_i) begin
    if (srst_i)
      uart0_double_baud_o <= 1'b0;
    else
      uart0_double_baud_o <= cfg_u0_dbl;
  end

  always @(posedge clk_i) begin
    if (srst_i)
      uart1_double_baud_o <= 1'b0;
    else
      uart1_double_baud_o <= cfg_u1_dbl;
  end
endmodule
`default_nettype wire

/* File: tb/pmcc_chk.sv */
// Purpose: port checker for pmcc_top
// Assumes: sfr write takes effect one cycle later
// Notes:   swb mirrors the last written enable bit
`timescale 1ns/10ps
`default_nettype none
module pmcc_chk (
  input wire logic       clk_i, srst_i, sfr_wr_i, irq_ack_i, stop_wake_i,
  input wire logic       uart0_receive_pin_i, uart0_rx_enable_i, uart0_tx_load_i,
  input wire logic [7:0] sfr_addr_i, sfr_wdata_i,
  input wire logic [1:0] sysclk_rate_select_i, sysclk_rate_o, power_mode_o,
  input wire logic       clk_divide_o, clk_gate_off_o, slow_tick_o,
  input wire logic       regulator_standby_o, uart0_double_baud_o
);
  logic switchback_enable;
  wire  cfg_wr = sfr_wr_i && sfr_addr_i == 8'h87;
  always @(posedge clk_i) begin
    if (srst_i) switchback_enable <= 1'b0;
    else if (cfg_wr) switchback_enable <= sfr_wdata_i[2];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence slow_idle;
    power_mode_o == 2'h1 && !sfr_wr_i;
  endsequence
  sequence wake_cause;
    irq_ack_i || uart0_tx_load_i || (uart0_rx_enable_i && $fell(uart0_receive_pin_i));
  endsequence
  rst_state_a: assert property (disable iff (1'b0)
    srst_i |=> power_mode_o == 2'h0 && !clk_divide_o && !clk_gate_off_o && slow_tick_o)
    else $error("state after reset");
  reduced_entry_a: assert property (
    cfg_wr && sfr_wdata_i == 8'h01 |=> power_mode_o == 2'h1 && clk_divide_o && !clk_gate_off_o)
    else $error("reduced entry");
  stop_gate_a: assert property (
    cfg_wr && sfr_wdata_i[1] && !stop_wake_i |=> clk_gate_off_o && power_mode_o == 2'h2)
    else $error("stop entry");
  rate_follow_a: assert property (
    !srst_i |=> sysclk_rate_o == $past(sysclk_rate_select_i)) else $error("rate copy");
  event_swb_a: assert property (
    switchback_enable ##0 slow_idle ##0 wake_cause |=> power_mode_o == 2'h0 && !clk_divide_o)
    else $error("switchback");
  no_swb_a: assert property (
    !switchback_enable ##0 slow_idle ##0 wake_cause |=> power_mode_o == 2'h1) else $error("no switchback");
  slow_tick_a: assert property (
    power_mode_o == 2'h0 [*3] |-> slow_tick_o) else $error("tick at full speed");
  cfg_bits_a: assert property (
    cfg_wr |=> regulator_standby_o == $past(sfr_wdata_i[3])
      && uart0_double_baud_o == $past(sfr_wdata_i[7])) else $error("config outputs");
endmodule
bind pmcc_top pmcc_chk i_chk (.*);
`default_nettype wire

/* File: tb/pmcc_uart_line.sv */
// Purpose: far-side uart lines for two receive pins
// Assumes: send_i bits pulse for one cycle
// Notes:   lines idle high, start bit held 9 cycles
`timescale 1ns/10ps
`default_nettype none
module pmcc_uart_line (
  input  wire logic       clk_i,  // system clock
  input  wire logic [1:0] send_i, // start a frame
  output var  logic [1:0] pin_o   // receive lines
);
  logic [3:0] cnt [2] = '{4'h0, 4'h0};
  always @(posedge clk_i) begin
    for (int k = 0; k < 2; k++) begin
      if (send_i[k]) cnt[k] <= 4'h9;
      else if (cnt[k] != 4'h0) cnt[k] <= cnt[k] - 4'h1;
    end
  end
  always_comb pin_o = {cnt[1] == 4'h0, cnt[0] == 4'h0};
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: self-checking bench for pmcc_top
// Assumes: 100 ns clock, reset 8 cycles
// Notes:   uart0 rx enable drops once to test the receive gating
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0, srst_i = 1'b1, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, irq_ack_i = 1'b0;
  logic uart0_rx_enable_i = 1'b1, uart1_rx_enable_i = 1'b1, stop_wake_i = 1'b0;
  logic uart0_tx_load_i = 1'b0, uart1_tx_load_i = 1'b0, uart0_rx_active_i = 1'b0;
  logic uart0_tx_active_i = 1'b0, uart1_rx_active_i = 1'b0, uart1_tx_active_i = 1'b0;
  logic low_prio_irq_active_i = 1'b0, high_prio_irq_active_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00;
  logic [1:0] sysclk_rate_select_i = 2'h0, send = 2'h0;
  wire  [7:0] sfr_rdata_o;
  wire  [1:0] sysclk_rate_o, power_mode_o;
  wire        clk_divide_o, clk_gate_off_o, slow_tick_o, regulator_standby_o;
  wire        progmem_write_enable_o, uart0_double_baud_o, uart1_double_baud_o;
  wire        uart0_receive_pin_i, uart1_receive_pin_i;
  logic [11:0] rows [8] = '{12'hF8F, 12'h081, 12'h102, 12'h200, 12'h404, 12'h808, 12'h040, 12'h000};
  int n_errors = 0;
  int n_checks = 0;
  pmcc_top i_dut (.*);
  pmcc_uart_line i_line (.clk_i(clk_i), .send_i(send),
                         .pin_o({uart1_receive_pin_i, uart0_receive_pin_i}));
  always #50 clk_i = ~clk_i;
  task automatic check(input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, d);
    @(posedge clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    {sfr_wr_i, sfr_rd_i} <= {w, !w};
    @(posedge clk_i);
    {sfr_wr_i, sfr_rd_i} <= 2'h0;
    @(negedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    bus(1'b0, a, 8'h00);
    check(sfr_rdata_o, exp);
  endtask
  // irq, rx0, rx1, tx0, tx1; long wait lets the line frame end
  task automatic pulse(input logic [4:0] c);
    @(posedge clk_i);
    {uart1_tx_load_i, uart0_tx_load_i, send, irq_ack_i} <= c;
    @(posedge clk_i);
    {uart1_tx_load_i, uart0_tx_load_i, send, irq_ack_i} <= 5'h00;
    repeat (12) @(negedge clk_i);
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    print_verdict();
  end
  initial begin
    int ticks;
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    @(negedge clk_i);
    check({clk_gate_off_o, clk_divide_o, slow_tick_o, 3'h0, power_mode_o}, 8'h20);
    rd(8'h87, 8'h00);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 8'h87, rows[i][11:4]);
      check({uart0_double_baud_o, uart1_double_baud_o, progmem_write_enable_o,
             regulator_standby_o}, rows[i][3:0]);
      rd(8'h87, rows[i][11:4]);
    end
    for (int r = 0; r < 3; r++) begin
      rd(8'hE9, 8'h00);
      @(posedge clk_i);
      sysclk_rate_select_i <= r[1:0];
      repeat (2) @(negedge clk_i);
      check(sysclk_rate_o, r[1:0]);
    end
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_i);
      {high_prio_irq_active_i, low_prio_irq_active_i, uart1_tx_active_i, uart1_rx_active_i,
       uart0_tx_active_i, uart0_rx_active_i} <= 6'h01 << k;
      rd(8'hE9, 8'h01 << (k < 4 ? k : k + 1));
    end
    @(posedge clk_i);
    high_prio_irq_active_i <= 1'b0;
    bus(1'b1, 8'hE9, 8'hFF);
    rd(8'hE9, 8'h00);
    rd(8'h55, 8'h00);
    bus(1'b1, 8'h87, 8'h01);
    check({clk_divide_o, power_mode_o}, 3'h5);
    ticks = 0;
    repeat (200) begin
      @(negedge clk_i);
      ticks += slow_tick_o;
    end
    check(ticks[7:0], 8'h02);
    for (int c = 0; c < 5; c++) begin
      pulse(5'h01 << c);
      check(power_mode_o, 2'h1);
    end
    for (int c = 0; c < 5; c++) begin
      bus(1'b1, 8'h87, 8'h05);
      pulse(5'h01 << c);
      rd(8'h87, 8'h04);
      check(clk_divide_o, 1'b0);
    end
    bus(1'b1, 8'h87, 8'h05);
    @(posedge clk_i);
    uart0_rx_enable_i <= 1'b0;
    pulse(5'h02);
    rd(8'h87, 8'h05);
    bus(1'b1, 8'h87, 8'h03);
    check({clk_gate_off_o, power_mode_o}, 3'h6);
    @(posedge clk_i);
    stop_wake_i <= 1'b1;
    @(posedge clk_i);
    stop_wake_i <= 1'b0;
    @(negedge clk_i);
    check(clk_gate_off_o, 1'b0);
    @(posedge clk_i);
    srst_i <= 1'b1;
    @(posedge clk_i);
    srst_i <= 1'b0;
    @(negedge clk_i);
    check({clk_gate_off_o, clk_divide_o, slow_tick_o, 3'h0, power_mode_o}, 8'h20);
    rd(8'h87, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
